/* File: verilog/gpio_expander_defines.svh */
// Purpose: Offsets, reset values and fixed patterns of the expander register map
// Assumes: Included by bare name from the register bank
// Notes: Command codes are the byte addresses the bus master loads into the pointer
`ifndef GPIO_EXPANDER_DEFINES_SVH
`define GPIO_EXPANDER_DEFINES_SVH

// Fixed upper six bits of the slave address
`define ADDR_FIXED 6'h10
// Command codes, basic map
`define CMD_IN_LO 8'h00
`define CMD_IN_HI 8'h01
`define CMD_OUT_LO 8'h02
`define CMD_OUT_HI 8'h03
`define CMD_INV_LO 8'h04
`define CMD_INV_HI 8'h05
`define CMD_DIR_LO 8'h06
`define CMD_DIR_HI 8'h07
// Command codes, extended map
`define CMD_DRV_0 8'h40
`define CMD_DRV_1 8'h41
`define CMD_DRV_2 8'h42
`define CMD_DRV_3 8'h43
`define CMD_HOLD_LO 8'h44
`define CMD_HOLD_HI 8'h45
`define CMD_PEN_LO 8'h46
`define CMD_PEN_HI 8'h47
`define CMD_PSEL_LO 8'h48
`define CMD_PSEL_HI 8'h49
`define CMD_MASK_LO 8'h4a
`define CMD_MASK_HI 8'h4b
`define CMD_PEND_LO 8'h4c
`define CMD_PEND_HI 8'h4d
`define CMD_STAGE 8'h4f
// Reset values
`define RST_ONES 8'hff
`define RST_ZERO 8'h00
// Position of the extended-group bit in the pointer
`define PTR_EXT_POS 6

`endif

/* File: verilog/gpio_expander_pkg.sv */
// Purpose: Types shared by the expander register bank and its users
// Assumes: Byte-level bus engine on the same clock drives bus_req_s
// Notes: Constants live in the defines header
package gpio_expander_pkg;

  // Byte events from the bus engine
  typedef struct packed {
    logic start;      // Start or repeated start seen
    logic stop;       // Stop seen
    logic addr_valid; // Address byte in data
    logic wr_valid;   // Written byte in data
    logic rd_req;     // Engine wants the next read byte
    logic [7:0] data; // Received byte
  } bus_req_s;

  // Read answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rd_rsp_s;

  // Configuration presented to the pin logic
  typedef struct packed {
    logic [15:0] out_value;
    logic [15:0] out_en_n;
    logic [31:0] drive;
    logic [15:0] hold_en;
    logic [15:0] pull_en;
    logic [15:0] pull_sel;
    logic [15:0] irq_mask;
    logic [7:0] out_stage;
  } pin_cfg_s;

  // Session states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD = 4'b0010,
    ST_WR = 4'b0100,
    ST_RD = 4'b1000
  } sess_e;

endpackage

/* File: verilog/gpio_expander_pointer_regmap.sv */
// Purpose: Slave-side pointer and register bank of a 16-bit bus I/O expander
// Assumes: A byte-level bus engine on sys_clk; pins and strap are asynchronous
// Notes: Pair auto-increment, latching and interrupt generation sit elsewhere
//
// Summary of operation
// - First written byte after address loads pointer
// - Pointer bit 6 plus low bits pick register
// - Pointer is write-only, never read back
// - Input level registers ignore writes entirely
// - Input level shows pin level in any direction
// - Input level has no reset value, follows pins
// - Output ones, inversion zeros, direction ones at reset
// - Four drive registers read/write, reset all ones
// - Hold enable registers read/write, reset zeros
// - Pull enable registers read/write, reset zeros
// - Pull select registers read/write, reset ones
// - Interrupt masks read/write, reset all ones
// - Interrupt pending registers read-only, reset zeros
// - Output stage register read/write, reset zeros
// - Strap level selects one of two addresses
// - Direction bit one reads, zero writes
// - Direction bit one means input, zero output
// - Output value reads back written value
`timescale 1ns/1ps
`default_nettype none
`include "gpio_expander_defines.svh"

module gpio_expander_pointer_regmap (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic addr_strap,
  input wire logic [15:0] pin_level,
  input wire logic [15:0] irq_pending_in,
  input wire gpio_expander_pkg::bus_req_s bus_req,
  output logic addr_match,
  output logic byte_ack,
  output var gpio_expander_pkg::rd_rsp_s rd_rsp,
  output var gpio_expander_pkg::pin_cfg_s pin_cfg
);

  // Reset release chain
  logic rst_meta_r;
  logic rst_n_r;
  // Strap synchroniser and capture
  logic strap_meta_r;
  logic strap_sync_r;
  logic strap_r;
  logic [2:0] strap_fill_r;
  // Pin synchroniser
  logic [15:0] pin_meta_r;
  logic [15:0] pin_sync_r;
  // Session and pointer
  gpio_expander_pkg::sess_e state_r;
  gpio_expander_pkg::sess_e state_nxt;
  logic [7:0] ptr_r;
  // Register storage
  logic [7:0] out_r [2];
  logic [7:0] inv_r [2];
  logic [7:0] dir_r [2];
  logic [7:0] drv_r [4];
  logic [7:0] hold_r [2];
  logic [7:0] pen_r [2];
  logic [7:0] psel_r [2];
  logic [7:0] mask_r [2];
  logic [7:0] pend_r [2];
  logic [7:0] stage_r;
  // Decoded values
  logic [15:0] in_level;
  logic [7:0] rd_mux;
  logic wr_data;

  // Reset released through two flops
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Strap and pins pass two flops
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      strap_meta_r <= 1'b0;
      strap_sync_r <= 1'b0;
      pin_meta_r <= 16'h0000;
      pin_sync_r <= 16'h0000;
    end else begin
      strap_meta_r <= addr_strap;
      strap_sync_r <= strap_meta_r;
      pin_meta_r <= pin_level;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Strap caught once after release, once its sync chain has filled
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      strap_r <= 1'b0;
      strap_fill_r <= 3'b000;
    end else if (!strap_fill_r[2]) begin
      strap_r <= strap_sync_r;
      strap_fill_r <= {strap_fill_r[1:0], 1'b1};
    end
  end

  // Address compare, handshake output
  always_comb begin
    addr_match = bus_req.addr_valid && strap_fill_r[2] &&
                 bus_req.data[7:1] == {`ADDR_FIXED, strap_r};
  end

  // Written bytes acknowledged while a write session is open
  always_comb begin
    byte_ack = bus_req.wr_valid &&
               (state_r == gpio_expander_pkg::ST_CMD || state_r == gpio_expander_pkg::ST_WR);
  end

  // A data write is any byte after the command byte
  assign wr_data = bus_req.wr_valid && state_r == gpio_expander_pkg::ST_WR;

  // Session next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      gpio_expander_pkg::ST_IDLE: begin
        if (addr_match) begin
          // Direction bit picks the session kind
          state_nxt = bus_req.data[0] ? gpio_expander_pkg::ST_RD
                                      : gpio_expander_pkg::ST_CMD;
        end
      end
      gpio_expander_pkg::ST_CMD: begin
        if (bus_req.wr_valid) begin
          state_nxt = gpio_expander_pkg::ST_WR;
        end
      end
      gpio_expander_pkg::ST_WR: begin
        state_nxt = gpio_expander_pkg::ST_WR;
      end
      gpio_expander_pkg::ST_RD: begin
        state_nxt = gpio_expander_pkg::ST_RD;
      end
      default: begin
        state_nxt = gpio_expander_pkg::ST_IDLE;
      end
    endcase
    // Start or stop closes any session; a start may re-address at once
    if (bus_req.stop || bus_req.start) begin
      state_nxt = gpio_expander_pkg::ST_IDLE;
    end
  end

  // Session state register
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= gpio_expander_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Pointer loaded only by the command byte of a write
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ptr_r <= `RST_ZERO;
    end else if (bus_req.wr_valid && state_r == gpio_expander_pkg::ST_CMD) begin
      ptr_r <= bus_req.data;
    end
  end

  // Register writes by pointer; inputs and pending are not writable
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      out_r <= '{`RST_ONES, `RST_ONES};
      inv_r <= '{`RST_ZERO, `RST_ZERO};
      dir_r <= '{`RST_ONES, `RST_ONES};
      drv_r <= '{`RST_ONES, `RST_ONES, `RST_ONES, `RST_ONES};
      hold_r <= '{`RST_ZERO, `RST_ZERO};
      pen_r <= '{`RST_ZERO, `RST_ZERO};
      psel_r <= '{`RST_ONES, `RST_ONES};
      mask_r <= '{`RST_ONES, `RST_ONES};
      stage_r <= `RST_ZERO;
    end else if (wr_data) begin
      case (ptr_r)
        `CMD_OUT_LO: out_r[0] <= bus_req.data;
        `CMD_OUT_HI: out_r[1] <= bus_req.data;
        `CMD_INV_LO: inv_r[0] <= bus_req.data;
        `CMD_INV_HI: inv_r[1] <= bus_req.data;
        `CMD_DIR_LO: dir_r[0] <= bus_req.data;
        `CMD_DIR_HI: dir_r[1] <= bus_req.data;
        `CMD_DRV_0: drv_r[0] <= bus_req.data;
        `CMD_DRV_1: drv_r[1] <= bus_req.data;
        `CMD_DRV_2: drv_r[2] <= bus_req.data;
        `CMD_DRV_3: drv_r[3] <= bus_req.data;
        `CMD_HOLD_LO: hold_r[0] <= bus_req.data;
        `CMD_HOLD_HI: hold_r[1] <= bus_req.data;
        `CMD_PEN_LO: pen_r[0] <= bus_req.data;
        `CMD_PEN_HI: pen_r[1] <= bus_req.data;
        `CMD_PSEL_LO: psel_r[0] <= bus_req.data;
        `CMD_PSEL_HI: psel_r[1] <= bus_req.data;
        `CMD_MASK_LO: mask_r[0] <= bus_req.data;
        `CMD_MASK_HI: mask_r[1] <= bus_req.data;
        `CMD_STAGE: stage_r <= bus_req.data;
        // Inputs, pending and unlisted codes change nothing
        default: stage_r <= stage_r;
      endcase
    end
  end

  // Pending copy from the interrupt logic, read-only here
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pend_r <= '{`RST_ZERO, `RST_ZERO};
    end else begin
      pend_r[0] <= irq_pending_in[7:0];
      pend_r[1] <= irq_pending_in[15:8];
    end
  end

  // Live pin level with optional inversion, no stored value
  always_comb begin
    in_level = pin_sync_r ^ {inv_r[1], inv_r[0]};
  end

  // Read decode; pointer itself is never a source
  always_comb begin
    rd_mux = `RST_ZERO;
    if (ptr_r[`PTR_EXT_POS]) begin
      case (ptr_r)
        `CMD_DRV_0: rd_mux = drv_r[0];
        `CMD_DRV_1: rd_mux = drv_r[1];
        `CMD_DRV_2: rd_mux = drv_r[2];
        `CMD_DRV_3: rd_mux = drv_r[3];
        `CMD_HOLD_LO: rd_mux = hold_r[0];
        `CMD_HOLD_HI: rd_mux = hold_r[1];
        `CMD_PEN_LO: rd_mux = pen_r[0];
        `CMD_PEN_HI: rd_mux = pen_r[1];
        `CMD_PSEL_LO: rd_mux = psel_r[0];
        `CMD_PSEL_HI: rd_mux = psel_r[1];
        `CMD_MASK_LO: rd_mux = mask_r[0];
        `CMD_MASK_HI: rd_mux = mask_r[1];
        `CMD_PEND_LO: rd_mux = pend_r[0];
        `CMD_PEND_HI: rd_mux = pend_r[1];
        `CMD_STAGE: rd_mux = stage_r;
        default: rd_mux = `RST_ZERO;
      endcase
    end else begin
      case (ptr_r)
        `CMD_IN_LO: rd_mux = in_level[7:0];
        `CMD_IN_HI: rd_mux = in_level[15:8];
        `CMD_OUT_LO: rd_mux = out_r[0];
        `CMD_OUT_HI: rd_mux = out_r[1];
        `CMD_INV_LO: rd_mux = inv_r[0];
        `CMD_INV_HI: rd_mux = inv_r[1];
        `CMD_DIR_LO: rd_mux = dir_r[0];
        `CMD_DIR_HI: rd_mux = dir_r[1];
        default: rd_mux = `RST_ZERO;
      endcase
    end
  end

  // Read answer one cycle after a request in a read session
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_rsp <= '0;
    end else begin
      rd_rsp.valid <= bus_req.rd_req && state_r == gpio_expander_pkg::ST_RD;
      if (bus_req.rd_req && state_r == gpio_expander_pkg::ST_RD) begin
        rd_rsp.data <= rd_mux;
      end
    end
  end

  // Configuration to the pin logic
  always_comb begin
    pin_cfg.out_value = {out_r[1], out_r[0]};
    pin_cfg.out_en_n = {dir_r[1], dir_r[0]};
    pin_cfg.drive = {drv_r[3], drv_r[2], drv_r[1], drv_r[0]};
    pin_cfg.hold_en = {hold_r[1], hold_r[0]};
    pin_cfg.pull_en = {pen_r[1], pen_r[0]};
    pin_cfg.pull_sel = {psel_r[1], psel_r[0]};
    pin_cfg.irq_mask = {mask_r[1], mask_r[0]};
    pin_cfg.out_stage = stage_r;
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_r);

  // Snapshot of writable state except psel_r[1] and both mask_r bytes
  logic [127:0] all_regs;
  assign all_regs = {out_r[0], out_r[1], inv_r[0], inv_r[1], dir_r[0], dir_r[1],
                     drv_r[0], drv_r[1], drv_r[2], drv_r[3], hold_r[0], hold_r[1],
                     pen_r[0], pen_r[1], psel_r[0], stage_r};

  sequence s_write_addr;
    state_r == gpio_expander_pkg::ST_IDLE && addr_match && !bus_req.data[0] &&
    !bus_req.start && !bus_req.stop;
  endsequence

  sequence s_cmd_byte;
    bus_req.wr_valid && !bus_req.start && !bus_req.stop;
  endsequence

  property p_addr_match;
    bus_req.addr_valid && strap_fill_r[2] && bus_req.data[7:1] == {6'h10, strap_r}
      |-> addr_match;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("address not matched");

  property p_cmd_load;
    s_write_addr ##1 s_cmd_byte |=> ptr_r == $past(bus_req.data) &&
                                    state_r == gpio_expander_pkg::ST_WR;
  endproperty
  a_cmd_load: assert property (p_cmd_load) else $error("command byte not stored");

  property p_read_dir;
    state_r == gpio_expander_pkg::ST_IDLE && addr_match && bus_req.data[0] &&
    !bus_req.start && !bus_req.stop |=> state_r == gpio_expander_pkg::ST_RD;
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("read session not opened");

  property p_ptr_stable;
    state_r != gpio_expander_pkg::ST_CMD |=> $stable(ptr_r);
  endproperty
  a_ptr_stable: assert property (p_ptr_stable) else $error("pointer moved outside command");

  property p_input_ro;
    wr_data && ptr_r[7:1] == 7'h00 |=> $stable(all_regs);
  endproperty
  a_input_ro: assert property (p_input_ro) else $error("input register write had effect");

  property p_input_read;
    bus_req.rd_req && state_r == gpio_expander_pkg::ST_RD && ptr_r == 8'h00
      |=> rd_rsp.valid && rd_rsp.data == $past(pin_sync_r[7:0] ^ inv_r[0]);
  endproperty
  a_input_read: assert property (p_input_read) else $error("input level read wrong");

  property p_out_readback;
    wr_data && ptr_r == 8'h02 |=> out_r[0] == $past(bus_req.data) &&
                                  pin_cfg.out_value[7:0] == $past(bus_req.data);
  endproperty
  a_out_readback: assert property (p_out_readback) else $error("output readback wrong");

  property p_reset_vals;
    $rose(rst_n_r) |-> out_r[0] == 8'hff && inv_r[0] == 8'h00 && dir_r[1] == 8'hff &&
                       drv_r[3] == 8'hff && mask_r[1] == 8'hff && pend_r[0] == 8'h00;
  endproperty
  a_reset_vals: assert property (@(posedge sys_clk) p_reset_vals) else $error("reset value wrong");

  property p_unlisted_zero;
    bus_req.rd_req && state_r == gpio_expander_pkg::ST_RD && ptr_r == 8'h4e
      |=> rd_rsp.data == 8'h00;
  endproperty
  a_unlisted_zero: assert property (p_unlisted_zero) else $error("unlisted code read nonzero");

  property p_dir_enable;
    pin_cfg.out_en_n == {dir_r[1], dir_r[0]} ##1 wr_data && ptr_r == 8'h06
      |=> pin_cfg.out_en_n[7:0] == $past(bus_req.data);
  endproperty
  a_dir_enable: assert property (p_dir_enable) else $error("direction not applied");

endmodule

`default_nettype wire

/* File: tb/bus_master_model.sv */
// Purpose: Byte-level bus master model that drives the expander bank
// Assumes: Requests launch just after a rising edge of sys_clk
// Notes: Unused data lines carry an inverted or 5a-xored pattern, never the last byte
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
  input wire logic sys_clk,
  input wire logic addr_match,
  input wire logic byte_ack,
  output var gpio_expander_pkg::bus_req_s bus_req
);
  logic seen_match; // Match flag seen on the last address byte
  logic seen_ack; // Ack flag seen on the last command byte

  // Bus quiet at time zero
  initial begin
    bus_req = '0;
    seen_match = 1'b0;
    seen_ack = 1'b0;
  end

  // One cycle of flags {start, stop, addr, wr, rd} with data
  task automatic put(input logic [4:0] f, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= {f, d};
  endtask

  // Start, then address byte: fixed pattern, strap bit, direction
  task automatic open(input logic strap, input logic rd);
    put(5'h10, ~bus_req.data);
    put(5'h04, {6'h10, strap, rd});
    @(negedge sys_clk);
    seen_match = addr_match;
  endtask

  // Command byte follows the address of a write session
  task automatic point(input logic strap, input logic [7:0] cmd);
    open(strap, 1'b0);
    put(5'h02, cmd);
    @(negedge sys_clk);
    seen_ack = byte_ack;
  endtask

  // Pointer load, one data byte, stop
  task automatic write(input logic strap, input logic [7:0] cmd, input logic [7:0] val);
    point(strap, cmd);
    put(5'h02, val);
    put(5'h08, ~val);
    put(5'h00, val ^ 8'h5a);
  endtask

  // Pointer load, repeated start for read, one byte request, stop
  task automatic read(input logic strap, input logic [7:0] cmd);
    point(strap, cmd);
    open(strap, 1'b1);
    put(5'h01, ~cmd);
    put(5'h08, cmd);
    put(5'h00, ~cmd);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_gpio_expander_pointer_regmap.sv */
// Purpose: Self-checking bench of the expander pointer and register bank
// Assumes: Master model issues whole sessions; a monitor checks read bytes
// Notes: Expected values come from a shadow copy of the register table
`timescale 1ns/1ps
`default_nettype none

module tb_gpio_expander_pointer_regmap;
  logic sys_clk; // Bench clock
  logic nrst; // Active-low reset
  logic addr_strap; // Strap pin level
  logic [15:0] pin_level; // Pin levels
  logic [15:0] irq_pending_in; // Pending bits in
  gpio_expander_pkg::bus_req_s bus_req; // From master model
  logic addr_match; // Address hit
  logic byte_ack; // Byte acknowledge
  gpio_expander_pkg::rd_rsp_s rd_rsp; // Read answer
  gpio_expander_pkg::pin_cfg_s pin_cfg; // Pin configuration
  int err_count = 0; // Mismatches
  int n_checks = 0; // Comparisons
  logic [7:0] exp_q[$]; // Expected read bytes, oldest first
  logic [7:0] shadow[0:255]; // Expected register contents by code

  gpio_expander_pointer_regmap DUT (
    .sys_clk(sys_clk), .nrst(nrst), .addr_strap(addr_strap), .pin_level(pin_level),
    .irq_pending_in(irq_pending_in), .bus_req(bus_req), .addr_match(addr_match),
    .byte_ack(byte_ack), .rd_rsp(rd_rsp), .pin_cfg(pin_cfg)
  );

  bus_master_model master (
    .sys_clk(sys_clk), .addr_match(addr_match), .byte_ack(byte_ack), .bus_req(bus_req)
  );

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic end_sim;
    $display("counts: checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compare one result
  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] s);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask

  // Table defaults: ones for output, direction, drive, pull select, mask
  task automatic init_shadow;
    for (int c = 0; c < 256; c++) begin
      shadow[c] = (c inside {[8'h02:8'h03], [8'h06:8'h07], [8'h40:8'h43], [8'h48:8'h4b]})
                  ? 8'hff : 8'h00;
    end
  endtask

  // Expected read byte for a command code
  function automatic logic [7:0] exp_of(input logic [7:0] c);
    case (c)
      8'h00: return pin_level[7:0] ^ shadow[4];
      8'h01: return pin_level[15:8] ^ shadow[5];
      8'h4c: return irq_pending_in[7:0];
      8'h4d: return irq_pending_in[15:8];
      default: return shadow[c];
    endcase
  endfunction

  // Reset with a given strap level, then let synchronisers settle
  task automatic do_reset(input logic s);
    @(posedge sys_clk);
    nrst <= 1'b0;
    addr_strap <= s;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge sys_clk);
    init_shadow();
  endtask

  // Write one register and note its effect in the shadow
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    master.write(addr_strap, c, v);
    chk("addr_match", 1, master.seen_match);
    chk("byte_ack", 1, master.seen_ack);
    if (c inside {[8'h02:8'h07], [8'h40:8'h4b], 8'h4f}) begin
      shadow[c] = v;
    end
  endtask

  // Read one register; the monitor compares the answer
  task automatic rd(input logic [7:0] c);
    exp_q.push_back(exp_of(c));
    master.read(addr_strap, c);
  endtask

  // Configuration outputs against the shadow
  task automatic chk_cfg;
    @(negedge sys_clk);
    chk("out_dir", {shadow[3], shadow[2], shadow[7], shadow[6]},
        {pin_cfg.out_value, pin_cfg.out_en_n});
    chk("hold_pull", {shadow[8'h45], shadow[8'h44], shadow[8'h47], shadow[8'h46],
        shadow[8'h49], shadow[8'h48], shadow[8'h4b], shadow[8'h4a]},
        {pin_cfg.hold_en, pin_cfg.pull_en, pin_cfg.pull_sel, pin_cfg.irq_mask});
    chk("stage", shadow[8'h4f], pin_cfg.out_stage);
    chk("drive", {shadow[8'h43], shadow[8'h42], shadow[8'h41], shadow[8'h40]}, pin_cfg.drive);
  endtask

  // Read monitor: every answer takes the oldest note
  always @(posedge sys_clk) begin
    if (rd_rsp.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("spurious_read", 0, 1);
      end else begin
        chk("rd_data", exp_q.pop_front(), rd_rsp.data);
      end
    end
  end

  // Watchdog, well beyond the expected run length
  initial begin
    #(20 * 40000);
    err_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    addr_strap = 1'b0;
    pin_level = 16'ha5c3;
    irq_pending_in = 16'h0000;
    void'($urandom(64));
    do_reset(1'b0);
    // Defaults of the whole map, unlisted codes read zero
    chk("drive_rst", 32'hffffffff, pin_cfg.drive);
    chk_cfg();
    for (int c = 0; c < 8'h50; c++) rd(8'(c));
    $display("test reset_map done");
    // Random writes to every code, read-only and unlisted ones ignored
    for (int c = 0; c < 8'h50; c++) wr(8'(c), 8'($urandom()));
    for (int c = 0; c < 8'h50; c++) rd(8'(c));
    chk_cfg();
    $display("test write_map done");
    // Pins and pending bits follow their sources
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      pin_level <= 16'($urandom());
      irq_pending_in <= 16'($urandom());
      repeat (4) @(posedge sys_clk);
      rd(8'h00);
      rd(8'h01);
      rd(8'h4c);
      rd(8'h4d);
    end
    $display("test pins_pending done");
    // Other strap address ignored; then reset mid-run with strap high
    master.write(1'b1, 8'h02, 8'h3c);
    chk("wrong_addr", 0, master.seen_match);
    master.read(1'b1, 8'h02);
    chk_cfg();
    do_reset(1'b1);
    chk_cfg();
    wr(8'h02, 8'h96);
    master.write(1'b0, 8'h02, 8'h11);
    chk("wrong_addr2", 0, master.seen_match);
    rd(8'h02);
    chk_cfg();
    $display("test strap done");
    repeat (5) @(posedge sys_clk);
    chk("reads_left", 0, exp_q.size());
    end_sim();
  end
endmodule
`default_nettype wire
